// File: light_sensor_alert_serial_slave.sv
/*
 * light sensor control: timed conversions, limit checks with fault
 * counting, open-drain alert pin and a two-wire serial slave that
 * returns the latest result, high byte first.
 * assumes light_level and the configuration ports come from logic on
 * sys_clk; scl, sda and addr_select come from pins.
 */
//
// Contract
// - integration period is 100 ms or 800 ms
// - conversion time select 1 picks the 800 ms conversion
// - range select code 1100b selects automatic range
// - automatic range picks the best range from the light level itself
// - after reset shut down; convert only once programmed active
// - continuous and single-shot conversion modes
// - each result is compared with high and low limits
// - alert after fault count consecutive identical faults; updates flags
// - latch mode picks latched window or transparent hysteresis
// - alert pin is open drain: pulls low or floats
// - polarity 0 pulls the pin low while alert is active
// - polarity 1 floats the pin while alert is active
// - address byte sampled on rising scl, last bit is direction
// - addressed device acks by pulling sda low in ninth pulse
// - each byte is eight bits plus one acknowledge bit
// - sda stable while scl high; changes there are start or stop
// - scl low for 28 ms resets the serial state machine
// - conversion takes integration time plus 3 ms
// - bytes go most significant bit first
// - slave address 1000100 to 1000111 from the address select pin
// - latched mode holds alert and flags until configuration read
`timescale 1ns/1ps
module light_sensor_alert_serial_slave #(
    parameter int CONV_SHORT = light_pkg::CONV_SHORT_CYC,
    parameter int CONV_LONG = light_pkg::CONV_LONG_CYC,
    parameter int TIMEOUT = light_pkg::TIMEOUT_CYC
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic scl,
    // configuration
    input wire light_pkg::config_t cfg,
    input wire logic config_write,
    input wire logic config_read,
    input wire logic [15:0] high_limit,
    input wire logic [15:0] low_limit,
    // front end
    input wire logic [light_pkg::LEVEL_W-1:0] light_level,
    // status
    output light_pkg::status_t status,
    output logic [light_pkg::RESULT_W-1:0] result,
    output logic converting,
    // serial pins
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] addr_select,
    // alert pin
    output logic int_o,
    output logic int_oe
);
    import light_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] encode(input logic [LEVEL_W-1:0] lvl,
                                           input logic [3:0] rs);
        logic [3:0] e;
        logic [LEVEL_W-1:0] sh;
        e = RANGE_MAX;
        if (rs == RANGE_AUTO) begin
            // smallest range that still holds the level
            for (int i = 11; i >= 0; i--) begin
                if ((lvl >> i) <= LEVEL_W'(MANT_MAX)) begin
                    e = 4'(i);
                end
            end
        end else if (rs < RANGE_MAX) begin
            e = rs;
        end
        sh = lvl >> e;
        if (sh > LEVEL_W'(MANT_MAX)) begin
            return {e, MANT_MAX};
        end
        return {e, sh[11:0]};
    endfunction

    function automatic logic [LIN_W-1:0] linear(input logic [15:0] x);
        return LIN_W'({16'h0000, x[11:0]} << x[15:12]);
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic [1:0] addr_m, addr_s;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
            addr_m <= 2'h0;
            addr_s <= 2'h0;
        end else begin
            scl_m <= scl;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_p <= sda_s;
            addr_m <= addr_select;
            addr_s <= addr_m;
        end
    end

    // ---------------------------------------------------------------
    // bus conditions and lockup timeout
    // ---------------------------------------------------------------
    logic start_ev, stop_ev, timeout_ev;
    logic bus_busy_q, link_clr_q;
    logic [TO_W-1:0] to_cnt_q;
    logic [6:0] addr_q;
    logic [15:0] snap_q;
    // edges of sda with scl high are framing, never data
    assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
    assign timeout_ev = bus_busy_q & ~scl_s &
                        (to_cnt_q == TO_W'(TIMEOUT - 1));

    always_ff @(posedge sys_clk) begin
        if (reset || !bus_busy_q || scl_s) begin
            to_cnt_q <= '0;
        end else if (!timeout_ev) begin
            to_cnt_q <= to_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_busy_q <= 1'b0;
        end else if (start_ev) begin
            bus_busy_q <= 1'b1;
        end else if (stop_ev || timeout_ev) begin
            bus_busy_q <= 1'b0;
        end
    end

    // holds the scl-side logic cleared outside frames; released only
    // while scl is low so no scl edge meets the release
    always_ff @(posedge sys_clk) begin
        if (reset || start_ev || stop_ev || timeout_ev || !bus_busy_q) begin
            link_clr_q <= 1'b1;
        end else if (!scl_s) begin
            link_clr_q <= 1'b0;
        end
    end

    // address and read data are frozen at the start, so the scl side
    // reads words that cannot move during a frame
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_q <= ADDR_BASE;
            snap_q <= RESULT_RST;
        end else if (start_ev) begin
            addr_q <= ADDR_BASE | {5'h00, addr_s};
            snap_q <= result;
        end
    end

    // ---------------------------------------------------------------
    // serial slave on scl
    // ---------------------------------------------------------------
    link_state_t lk_q;
    logic [3:0] bit_q;
    logic [7:0] rx_q;
    logic byte_sel_q, sda_oe_q;
    logic [7:0] tx_byte;
    logic addr_hit;
    assign tx_byte = byte_sel_q ? snap_q[7:0] : snap_q[15:8];
    assign addr_hit = (rx_q[7:1] == addr_q);

    always_ff @(posedge scl or posedge link_clr_q) begin
        if (link_clr_q) begin
            lk_q <= LK_ADDR;
            bit_q <= 4'h0;
            rx_q <= 8'h00;
            byte_sel_q <= 1'b0;
        end else if (bit_q != ACK_BIT) begin
            rx_q <= {rx_q[6:0], sda_i};
            bit_q <= bit_q + 1'b1;
        end else begin
            bit_q <= 4'h0;
            unique case (lk_q)
                LK_ADDR: begin
                    // last address bit is the direction
                    lk_q <= !addr_hit ? LK_IGNORE :
                            (rx_q[0] ? LK_READ : LK_WRITE);
                    byte_sel_q <= 1'b0;
                end
                LK_READ: begin
                    // master nack ends the read
                    if (sda_i) begin
                        lk_q <= LK_IGNORE;
                    end
                    byte_sel_q <= ~byte_sel_q;
                end
                LK_WRITE: lk_q <= LK_WRITE;
                LK_IGNORE: lk_q <= LK_IGNORE;
            endcase
        end
    end

    // sda changes only after falling scl, never while scl is high
    always_ff @(negedge scl or posedge link_clr_q) begin
        if (link_clr_q) begin
            sda_oe_q <= 1'b0;
        end else if (bit_q == ACK_BIT) begin
            sda_oe_q <= (lk_q == LK_ADDR && addr_hit) ||
                        (lk_q == LK_WRITE);
        end else if (lk_q == LK_READ) begin
            sda_oe_q <= ~tx_byte[~bit_q[2:0]];
        end else begin
            sda_oe_q <= 1'b0;
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_q;

    // ---------------------------------------------------------------
    // conversion timing
    // ---------------------------------------------------------------
    conv_state_t cv_q;
    logic [CNT_W-1:0] cnt_q, len_last;
    logic ct_q, start_conv, done;
    assign start_conv = config_write && cfg.mode != MODE_SHUTDOWN;
    // integration plus fixed overhead
    assign len_last = (ct_q == CT_LONG) ? CNT_W'(CONV_LONG - 1)
                                        : CNT_W'(CONV_SHORT - 1);
    assign done = (cv_q == CV_RUN) && (cnt_q == len_last);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cv_q <= CV_OFF;
            cnt_q <= '0;
            ct_q <= 1'b0;
        end else if (start_conv) begin
            cv_q <= CV_RUN;
            cnt_q <= '0;
            ct_q <= cfg.conversion_time_select;
        end else if (config_write) begin
            cv_q <= CV_OFF;
            cnt_q <= '0;
        end else if (done) begin
            cnt_q <= '0;
            // single shot stops, continuous starts the next one
            cv_q <= (cfg.mode == MODE_SINGLE) ? CV_OFF : CV_RUN;
        end else if (cv_q == CV_RUN) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign converting = (cv_q == CV_RUN);

    // ---------------------------------------------------------------
    // result and fault counting
    // ---------------------------------------------------------------
    logic [15:0] new_res, result_q;
    fault_t outcome, prev_q;
    logic [3:0] run_q, run_len, need;
    logic ev_high, ev_low;
    assign new_res = encode(light_level, cfg.range_select);
    always_comb begin
        outcome = FAULT_NONE;
        if (linear(new_res) > linear(high_limit)) begin
            outcome = FAULT_HIGH;
        end else if (linear(new_res) < linear(low_limit)) begin
            outcome = FAULT_LOW;
        end
    end
    // a changed outcome starts a fresh run
    assign run_len = (outcome != prev_q) ? 4'h1 :
                     (run_q == FAULT_RUN_MAX) ? run_q : run_q + 1'b1;
    assign need = 4'h1 << cfg.fault_count;
    assign ev_high = done && outcome == FAULT_HIGH && run_len >= need;
    assign ev_low = done && outcome == FAULT_LOW && run_len >= need;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            result_q <= RESULT_RST;
        end else if (done) begin
            result_q <= new_res;
        end
    end
    assign result = result_q;

    always_ff @(posedge sys_clk) begin
        if (reset || start_conv) begin
            prev_q <= FAULT_NONE;
            run_q <= 4'h0;
        end else if (done) begin
            prev_q <= outcome;
            run_q <= run_len;
        end
    end

    // ---------------------------------------------------------------
    // flags and alert pin
    // ---------------------------------------------------------------
    logic flag_high_q, flag_low_q, ready_q, int_act_q, int_oe_q, rd_clr;
    assign rd_clr = config_read && cfg.latch_mode;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flag_high_q <= 1'b0;
            flag_low_q <= 1'b0;
            int_act_q <= 1'b0;
        end else if (cfg.latch_mode) begin
            // latched window: hold until read, a new event wins
            flag_high_q <= ev_high | (flag_high_q & ~rd_clr);
            flag_low_q <= ev_low | (flag_low_q & ~rd_clr);
            int_act_q <= ev_high | ev_low | (int_act_q & ~rd_clr);
        end else if (ev_high) begin
            // transparent hysteresis: high sets, low clears
            flag_high_q <= 1'b1;
            flag_low_q <= 1'b0;
            int_act_q <= 1'b1;
        end else if (ev_low) begin
            flag_high_q <= 1'b0;
            flag_low_q <= 1'b1;
            int_act_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ready_q <= 1'b0;
        end else if (done) begin
            ready_q <= 1'b1;
        end else if (config_read || start_conv) begin
            ready_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            int_oe_q <= 1'b0;
        end else begin
            // polarity 0 pulls low when active, 1 floats
            int_oe_q <= int_act_q ^ cfg.interrupt_polarity;
        end
    end
    assign int_o = 1'b0;
    assign int_oe = int_oe_q;
    assign status = '{conversion_ready: ready_q, flag_high: flag_high_q,
                      flag_low: flag_low_q};
endmodule

// File: light_pkg.sv
/*
 * constants, timing counts and carrier types of the light sensor block.
 * assumes a 125 MHz system clock; the cycle counts are derived from it here, while CNT_W and TO_W are fixed.
 */
package light_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int SYS_CLK_HZ = 125_000_000;
    localparam int CYC_PER_MS = SYS_CLK_HZ / 1000;
    localparam int INT_SHORT_MS = 100;
    localparam int INT_LONG_MS = 800;
    localparam int CONV_EXTRA_MS = 3;
    localparam int BUS_TIMEOUT_MS = 28;
    localparam int CONV_SHORT_CYC = (INT_SHORT_MS + CONV_EXTRA_MS) * CYC_PER_MS;
    localparam int CONV_LONG_CYC = (INT_LONG_MS + CONV_EXTRA_MS) * CYC_PER_MS;
    localparam int TIMEOUT_CYC = BUS_TIMEOUT_MS * CYC_PER_MS;
    localparam int CNT_W = 27;
    localparam int TO_W = 22;
    // ---------------------------------------------------------------
    // fields and codes
    // ---------------------------------------------------------------
    localparam int LEVEL_W = 20;
    localparam int RESULT_W = 16;
    localparam int LIN_W = 28;
    localparam logic [3:0] RANGE_AUTO = 4'hC;
    localparam logic [3:0] RANGE_MAX = 4'hB;
    localparam logic [11:0] MANT_MAX = 12'hFFF;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic CT_LONG = 1'b1;
    localparam logic [6:0] ADDR_BASE = 7'h44;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] FAULT_RUN_MAX = 4'h8;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic conversion_time_select;
        logic [3:0] range_select;
        logic latch_mode;
        logic interrupt_polarity;
        logic [1:0] fault_count;
    } config_t;
    typedef struct packed {
        logic conversion_ready;
        logic flag_high;
        logic flag_low;
    } status_t;
    typedef enum logic [1:0] {
        FAULT_NONE = 2'b00,
        FAULT_HIGH = 2'b01,
        FAULT_LOW = 2'b10
    } fault_t;
    typedef enum logic [1:0] {
        LK_ADDR = 2'b00,
        LK_WRITE = 2'b01,
        LK_READ = 2'b10,
        LK_IGNORE = 2'b11
    } link_state_t;
    typedef enum logic {
        CV_OFF = 1'b0,
        CV_RUN = 1'b1
    } conv_state_t;
endpackage

// File: light_sensor_alert_serial_slave_chk.sv
/* port checker of the light sensor block.
   bound below to every instance of the block. */
`timescale 1ns/1ps
module light_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // controls
    input wire light_pkg::config_t cfg,
    input wire logic config_write,
    input wire logic config_read,
    // outputs
    input wire light_pkg::status_t status,
    input wire logic [15:0] result,
    input wire logic converting,
    input wire logic sda_o,
    input wire logic int_o,
    input wire logic int_oe
);
    import light_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic go;
    assign go = config_write && cfg.mode != MODE_SHUTDOWN;
    a_pins_open_drain: assert property (!int_o && !sda_o)
        else $error("pin driven high");
    a_result_at_done: assert property ($changed(result) |->
        status.conversion_ready) else $error("result moved early");
    a_start_runs: assert property (go |=> converting)
        else $error("no conversion after write");
    a_stop_halts: assert property (config_write &&
        cfg.mode == MODE_SHUTDOWN |=> !converting)
        else $error("shutdown ignored");
    a_ready_waits: assert property (go && !converting |=>
        !status.conversion_ready [*8]) else $error("ready too soon");
    a_conv_length: assert property ($rose(converting) ##1
        (!config_write) [*7] |-> converting)
        else $error("conversion too short");
    a_read_clears: assert property (config_read && cfg.latch_mode &&
        !converting |=> !status.flag_high && !status.flag_low)
        else $error("latched flags kept");
    a_int_pull_low: assert property ($rose(status.flag_high) &&
        cfg.latch_mode && !cfg.interrupt_polarity |=> int_oe)
        else $error("alert not pulled low");
    a_int_float: assert property ($rose(status.flag_high) &&
        cfg.interrupt_polarity |=> !int_oe) else $error("alert not floated");
    c_single: cover property (config_write && cfg.mode == MODE_SINGLE);
    c_low_event: cover property ($rose(status.flag_low));
    c_done: cover property ($fell(converting));
endmodule

bind light_sensor_alert_serial_slave light_chk light_chk_inst (
    .sys_clk(sys_clk), .reset(reset), .cfg(cfg),
    .config_write(config_write), .config_read(config_read),
    .status(status), .result(result), .converting(converting),
    .sda_o(sda_o), .int_o(int_o), .int_oe(int_oe)
);

// File: light_master.sv
/* serial bus master model: start, stop, bit and byte transfers.
   assumes a pull-up on sda; the model only ever pulls it low. */
`timescale 1ns/1ps
module light_master (
    // serial pins
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    logic tick;
    initial begin
        tick = 1'b0;
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // 6 ns timebase; phases of 8 ticks keep framing edges long enough
    // for the block's oversampled start and stop detection
    always #3 tick = ~tick;
    task automatic step;
        repeat (8) @(posedge tick);
    endtask
    task automatic start;
        sda_pull = 1'b1;
        step;
        scl = 1'b0;
        step;
    endtask
    task automatic stop;
        sda_pull = 1'b1;
        step;
        scl = 1'b1;
        step;
        sda_pull = 1'b0;
        step;
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_pull = ~b;
        step;
        scl = 1'b1;
        step;
        s = sda;
        scl = 1'b0;
        step;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask
endmodule

// File: light_sensor_alert_serial_slave_tb_top.sv
/* self-checking bench of the light sensor block.
   serial traffic comes from light_master; sda has a pull-up. */
`timescale 1ns/1ps
module light_sensor_alert_serial_slave_tb_top;
    import light_pkg::*;
    localparam int NS = 200;
    localparam int NL = 400;
    localparam int NT = 300;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic scl, sda_pull, sda_o, sda_oe, int_o, int_oe, converting;
    logic config_write = 1'b0;
    logic config_read = 1'b0;
    logic [15:0] high_limit = 16'hBFFF;
    logic [15:0] low_limit = 16'h0000;
    logic [19:0] light_level = 20'h00000;
    logic [1:0] addr_select = 2'h0;
    logic [15:0] result;
    logic [15:0] exp_res = 16'h0000;
    config_t cfg = 11'h000;
    status_t status;
    wire sda;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    assign sda = !(sda_pull || sda_oe);
    always #4 sys_clk = ~sys_clk;
    light_sensor_alert_serial_slave #(.CONV_SHORT(NS), .CONV_LONG(NL),
        .TIMEOUT(NT)) light_sensor_alert_serial_slave_inst (
        .sys_clk(sys_clk), .reset(reset), .scl(scl), .cfg(cfg),
        .config_write(config_write), .config_read(config_read),
        .high_limit(high_limit), .low_limit(low_limit),
        .light_level(light_level), .status(status), .result(result),
        .converting(converting), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select(addr_select), .int_o(int_o),
        .int_oe(int_oe));
    light_master light_master_inst (.scl(scl), .sda_pull(sda_pull),
        .sda(sda));
    // wide enough for the 21-bit reset snapshot compared after release
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        check_count++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim;
        end
    end
    task automatic cyc_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic set_cfg(input logic [10:0] c);
        @(negedge sys_clk);
        cfg = c;
        config_write = 1'b1;
        @(negedge sys_clk);
        config_write = 1'b0;
    endtask
    task automatic pulse_rd;
        @(negedge sys_clk);
        config_read = 1'b1;
        @(negedge sys_clk);
        config_read = 1'b0;
    endtask
    task automatic one_shot(input logic ct, input logic [3:0] rn,
            input logic [19:0] lvl, input logic [15:0] want);
        light_level = lvl;
        set_cfg({MODE_SINGLE, ct, rn, 4'h0});
        check(converting, 1);
        cyc_n((ct ? NL : NS) - 1);
        check({status.conversion_ready, result}, {1'b0, exp_res});
        cyc_n(1);
        check({status.conversion_ready, converting, result},
            {2'b10, want});
        exp_res = want;
    endtask
    // wait for the next completion of a running conversion
    task automatic next_done;
        int n;
        n = 0;
        pulse_rd;
        while (status.conversion_ready !== 1'b1 && n < 500) begin
            @(negedge sys_clk);
            n++;
        end
        check(n < 500, 1);
        cyc_n(2);
    endtask
    task automatic t_latched;
        high_limit = 16'h0100;
        set_cfg({2'h3, 1'b0, 4'h0, 1'b1, 1'b0, 2'h1});
        next_done;
        check({status.flag_high, int_oe}, 2'b00);
        next_done;
        check({status.flag_high, status.flag_low, int_oe}, 3'b101);
        set_cfg({2'h0, 1'b0, 4'h0, 1'b1, 1'b0, 2'h1});
        check({converting, status.flag_high}, 2'b01);
        pulse_rd;
        cyc_n(1);
        check({status.flag_high, int_oe}, 2'b00);
    endtask
    task automatic t_transparent;
        set_cfg({2'h3, 1'b0, 4'h0, 1'b0, 1'b1, 2'h1});
        next_done;
        high_limit = 16'hBFFF;
        low_limit = 16'hBFFF;
        next_done;
        check({status.flag_high, status.flag_low, int_oe}, 3'b001);
        next_done;
        check({status.flag_high, status.flag_low, int_oe}, 3'b011);
        low_limit = 16'h0000;
        high_limit = 16'h0100;
        next_done;
        next_done;
        check({status.flag_high, status.flag_low, int_oe}, 3'b100);
        set_cfg({2'h0, 1'b0, 4'h0, 1'b0, 1'b1, 2'h1});
        pulse_rd;
        check(status.flag_high, 1);
    endtask
    task automatic t_serial;
        logic [7:0] hi, lo;
        logic ack;
        for (int s = 0; s < 4; s++) begin
            @(negedge sys_clk);
            addr_select = s[1:0];
            light_master_inst.start;
            light_master_inst.xfer({ADDR_BASE | 7'(s ^ 1), 1'b1}, hi);
            light_master_inst.bit_io(1'b1, ack);
            light_master_inst.stop;
            check(ack, 1);
            light_master_inst.start;
            light_master_inst.xfer({ADDR_BASE | 7'(s), 1'b1}, hi);
            light_master_inst.bit_io(1'b1, ack);
            check(ack, 0);
            light_master_inst.xfer(8'hFF, hi);
            light_master_inst.bit_io(1'b0, ack);
            light_master_inst.xfer(8'hFF, lo);
            light_master_inst.bit_io(1'b1, ack);
            light_master_inst.stop;
            check({hi, lo}, exp_res);
        end
    endtask
    task automatic t_timeout;
        logic [7:0] d;
        light_master_inst.start;
        light_master_inst.xfer({ADDR_BASE | 7'(addr_select), 1'b0}, d);
        cyc_n(2);
        check(sda_oe, 1);
        cyc_n(NT + 20);
        check(sda_oe, 0);
        light_master_inst.stop;
    endtask
    initial begin
        cyc_n(10);
        reset = 1'b0;
        cyc_n(2);
        check({status, converting, int_oe, result}, 20'h0);
        one_shot(1'b0, RANGE_AUTO, 20'h12345, 16'h591A);
        one_shot(1'b0, RANGE_AUTO, 20'hFFFFF, 16'h8FFF);
        one_shot(CT_LONG, 4'h0, 20'h00ABC, 16'h0ABC);
        t_latched;
        t_transparent;
        t_serial;
        t_timeout;
        end_sim;
    end
endmodule
